// [inc/mac_pkg.sv]
package mac_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SLOT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CRC_CNT = 8'h0C;
  localparam logic [7:0] OFF_ALIGN_CNT = 8'h10;
  localparam logic [7:0] OFF_MISS_CNT = 8'h14;

  // Control register fields
  localparam int CTRL_ACCEPT_RUNTS = 0;
  localparam int CTRL_ACCEPT_ERRORS = 1;
  localparam int CTRL_MONITOR = 2;
  localparam int CTRL_LONG_CHECK = 3;
  localparam int CTRL_NIBBLE = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_001F;

  // Frame status fields
  localparam int ST_RECEIVED = 0;
  localparam int ST_CRC_ERR = 1;
  localparam int ST_ALIGN_ERR = 2;
  localparam int ST_RUNT = 3;
  localparam int ST_LONG = 4;
  localparam int ST_OVERFLOW = 5;
  localparam int ST_MISSED = 6;
  localparam int ST_COUNT_LSB = 16;

  // Slot time in bit times
  localparam logic [15:0] SLOT_RESET = 16'h0200;

  // Frame figures
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [2:0] SFD_INDEX = 3'h7;
  localparam logic [15:0] LONG_BYTES = 16'h05EE;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC_RESIDUE = 32'hC704_DD7B;

  // Event counters
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ALERT = 8'hC0;

  // Deference in bit times
  localparam logic [7:0] IFG_BITS = 8'h60;
  localparam logic [7:0] OBSERVE_BITS = 8'h40;

  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_CRC} tx_state_t;

endpackage

// [logic/mac_crc_byte.sv]
`timescale 1ns/10ps
`default_nettype none
module mac_crc_byte
  import mac_pkg::*;
(
  input wire logic [31:0] crc,
  input wire logic [7:0] data,
  output logic [31:0] next_crc
);

  // Reflected CRC-32, data taken least significant bit first
  always_comb
  begin
    next_crc = crc;
    for (int i = 0; i < 8; i++)
    begin
      if (next_crc[0] ^ data[i])
        next_crc = (next_crc >> 1) ^ CRC_POLY;
      else
        next_crc = next_crc >> 1;
    end
  end

endmodule
`default_nettype wire

// [logic/mac_frame.sv]
// Operation
// R01: Byte count starts at the delimiter byte and runs until frame end or abort; the code keeps counting after an abort until frame end.
// R02: Frames not longer than the slot time are runts, dropped unless runts accepted.
// R03: Data after the delimiter sits in an 8-dword FIFO; burst request at six.
// R04: A rejected destination address stops FIFO writes and empties the FIFO.
// R05: Monitor mode checks and counts but stores nothing; good frames count as missed.
// R06: Memory full mid-frame aborts it, pulses overflow, counts it missed.
// R07: Bad CRC flags status, counts, and aborts unless errored frames are accepted.
// R08: Bad CRC with a partial last byte also flags and counts an alignment error.
// R09: A CRC error outside monitor mode pulses the receive error interrupt.
// R10: With long checking on, frames over 1518 bytes are long and not error-counted.
// R11: Status is posted at every frame end and held until the next frame ends.
// R12: Three 8-bit counters saturate at 255 and clear when read.
// R13: One shared counter interrupt fires when any counter reaches 192.
// R14: Each sent frame opens with 56 preamble bits then delimiter 10101011.
// R15: Serial mode sends each byte on data line zero, least significant bit first.
// R16: Nibble mode sends low nibble first, bit zero on line zero.
// R17: CRC is computed and appended, most significant bit first.
// R18: A frame marked no-CRC is sent without the appended CRC.
// R19: A two-part deference timer starts after carrier and collision end; no start meanwhile.
// R20: Activity during the observe part clears the timer and holds it at zero.
// R21: After the observe part activity is ignored; expiry starts a queued frame.
// R22: Slot time defaults to 512 bit times and is programmable.
// R23: A received CRC is good only when the residue is C704DD7B.
// R24: Deference parts total 96 bit times, observe part the first two thirds.
`timescale 1ns/10ps
`default_nettype none
module mac_frame
  import mac_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int FIFO_BURST = 6
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic rx_clk,
  input wire logic crs,
  input wire logic col,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic [3:0] rxd,
  input wire logic tx_clk,
  output logic tx_en,
  output logic [3:0] txd,
  input wire logic addr_reject,
  input wire logic mem_full,
  output logic mem_burst_req,
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [31:0] mem_data,
  output logic frame_done,
  output logic frame_keep,
  output logic [31:0] frame_status,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_no_crc,
  output logic tx_ready,
  output logic irq_overflow,
  output logic irq_rx_error,
  output logic irq_counter
);

  localparam int PW = $clog2(FIFO_DEPTH);

  initial
  begin
    if (FIFO_DEPTH != 2 ** PW || FIFO_BURST < 1 || FIFO_BURST > FIFO_DEPTH)
      $error("mac_frame: FIFO_DEPTH must be a power of two and FIFO_BURST fit in it");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage one is read only by stage two
  logic [9:0] sync1;
  logic [9:0] sync2;
  logic rx_clk_d;
  logic tx_clk_d;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      rx_clk_d <= 1'b0;
      tx_clk_d <= 1'b0;
    end
    else
    begin
      sync1 <= {tx_clk, rx_clk, crs, col, rx_dv, rx_er, rxd};
      sync2 <= sync1;
      rx_clk_d <= sync2[8];
      tx_clk_d <= sync2[9];
    end
  end

  wire [3:0] rxd_s = sync2[3:0];
  wire rx_er_s = sync2[4];
  wire rx_dv_s = sync2[5];
  wire col_s = sync2[6];
  wire crs_s = sync2[7];
  wire rx_edge = sync2[8] && !rx_clk_d;
  wire tx_edge = sync2[9] && !tx_clk_d;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state
  logic [31:0] ctrl;
  logic [15:0] slot_bits;
  logic [7:0] cnt [3];
  logic [2:0] cnt_inc;

  wire access = cyc_i && stb_i && !ack_o;
  wire [7:0] waddr = {adr_i[7:2], 2'b00};
  wire [31:0] lane = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire wr_ctrl = access && we_i && waddr == OFF_CTRL;
  wire wr_slot = access && we_i && waddr == OFF_SLOT;
  wire [2:0] rd_clr = {access && !we_i && waddr == OFF_MISS_CNT,
                       access && !we_i && waddr == OFF_ALIGN_CNT,
                       access && !we_i && waddr == OFF_CRC_CNT};
  wire [31:0] rd_val =
    waddr == OFF_CTRL ? ctrl :
    waddr == OFF_SLOT ? {16'h0000, slot_bits} :
    waddr == OFF_STATUS ? frame_status :
    waddr == OFF_CRC_CNT ? {24'h00_0000, cnt[0]} :
    waddr == OFF_ALIGN_CNT ? {24'h00_0000, cnt[1]} :
    waddr == OFF_MISS_CNT ? {24'h00_0000, cnt[2]} : 32'h0000_0000;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
      ctrl <= CTRL_RESET;
      slot_bits <= SLOT_RESET;
    end
    else
    begin
      ack_o <= access;
      dat_o <= access && !we_i ? rd_val : 32'h0000_0000;
      if (wr_ctrl)
        ctrl <= ((ctrl & ~lane) | (dat_i & lane)) & CTRL_MASK;
      if (wr_slot)
        slot_bits <= (slot_bits & ~lane[15:0]) | (dat_i[15:0] & lane[15:0]); // R22
    end
  end

  wire nibble = ctrl[CTRL_NIBBLE];
  wire monitor = ctrl[CTRL_MONITOR];

  ////////////////////////////////////////////////////////////////////////////
  // Receive framing
  logic [7:0] rx_sh;
  logic in_frame;
  logic [3:0] bit_cnt;
  logic [15:0] byte_cnt;
  logic [31:0] rx_crc;
  logic [31:0] rx_crc_nx;
  logic storing;
  logic rejected;
  logic overflow;
  logic rxer_seen;
  logic [1:0] lane_idx;
  logic [31:0] word;
  logic was_active;

  wire active = nibble ? rx_dv_s : (crs_s || col_s);
  wire [7:0] sh_next = nibble ? {rxd_s, rx_sh[7:4]} : {rxd_s[0], rx_sh[7:1]};
  wire [3:0] step = nibble ? 4'h4 : 4'h1;
  wire [3:0] bit_next = bit_cnt + step;
  wire rx_unit = rx_edge && active;
  wire sfd_hit = rx_unit && !in_frame && sh_next == SFD_BYTE;
  wire byte_done = rx_unit && in_frame && bit_next[3];
  wire frame_end = in_frame && was_active && !active;
  wire push = byte_done && storing && lane_idx == 2'b11;
  wire flush = frame_end && storing && lane_idx != 2'b00;
  wire go_over = in_frame && storing && !monitor && mem_full;

  mac_crc_byte u_rx_crc (
    .crc(rx_crc),
    .data(sh_next),
    .next_crc(rx_crc_nx)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_sh <= '0;
      in_frame <= 1'b0;
      bit_cnt <= '0;
      byte_cnt <= '0;
      rx_crc <= CRC_INIT;
      storing <= 1'b0;
      rejected <= 1'b0;
      overflow <= 1'b0;
      rxer_seen <= 1'b0;
      lane_idx <= '0;
      word <= '0;
      was_active <= 1'b0;
    end
    else
    begin
      was_active <= active;
      if (rx_unit)
        rx_sh <= sh_next;
      if (sfd_hit)
      begin
        in_frame <= 1'b1;
        bit_cnt <= '0;
        byte_cnt <= 16'h0001; // R01
        rx_crc <= CRC_INIT;
        storing <= !monitor; // R05
        rejected <= 1'b0;
        overflow <= 1'b0;
        rxer_seen <= 1'b0;
        lane_idx <= '0;
        rx_sh <= '0;
      end
      else if (frame_end)
      begin
        in_frame <= 1'b0;
        storing <= 1'b0;
        // Stale bits could fake a delimiter early in the next preamble
        rx_sh <= '0;
      end
      else if (rx_unit && in_frame)
      begin
        bit_cnt <= bit_next[3] ? 4'h0 : bit_next;
        if (nibble && rx_er_s)
          rxer_seen <= 1'b1;
        if (byte_done)
        begin
          byte_cnt <= byte_cnt + 16'h0001; // R01
          rx_crc <= rx_crc_nx;
          word[8*lane_idx +: 8] <= sh_next;
          lane_idx <= lane_idx + 2'b01;
        end
        else
          word[8*lane_idx +: 8] <= sh_next;
      end
      if (in_frame && addr_reject)
      begin
        storing <= 1'b0; // R04
        rejected <= 1'b1;
      end
      if (go_over)
      begin
        storing <= 1'b0; // R06
        overflow <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO toward local memory
  logic [31:0] fifo [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fifo_cnt;

  wire fifo_full = fifo_cnt == (PW+1)'(FIFO_DEPTH);
  wire fifo_wr = (push || flush) && !fifo_full;
  wire [31:0] fifo_din = push ? {sh_next, word[23:0]} : word;
  wire fifo_rd = mem_valid && mem_ready;
  wire fifo_clear = in_frame && addr_reject;

  assign mem_valid = fifo_cnt != '0;
  assign mem_data = fifo[rd_ptr];
  assign mem_burst_req = fifo_cnt >= (PW+1)'(FIFO_BURST) || (!in_frame && mem_valid); // R03

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end
    else if (fifo_clear)
    begin
      wr_ptr <= '0; // R04
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end
    else
    begin
      if (fifo_wr)
        wr_ptr <= wr_ptr + 1'b1; // R03
      if (fifo_rd)
        rd_ptr <= rd_ptr + 1'b1;
      fifo_cnt <= fifo_cnt + (PW+1)'(fifo_wr) - (PW+1)'(fifo_rd);
    end
  end

  always_ff @(posedge clk)
  begin
    if (fifo_wr)
      fifo[wr_ptr] <= fifo_din;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame checks, status and event counters
  wire crc_bad = {<<{rx_crc}} != CRC_RESIDUE || rxer_seen; // R23
  wire runt = byte_cnt <= {3'b000, slot_bits[15:3]}; // R02
  wire long_err = ctrl[CTRL_LONG_CHECK] && byte_cnt > LONG_BYTES + 16'h0001; // R10
  wire align_err = bit_cnt != 4'h0 && crc_bad; // R08
  wire acceptable = !rejected && (!runt || ctrl[CTRL_ACCEPT_RUNTS])
                    && (!crc_bad || ctrl[CTRL_ACCEPT_ERRORS]) && !long_err; // R02 R07
  wire missed = overflow || (monitor && acceptable); // R05 R06

  assign cnt_inc = {frame_end && missed,
                    frame_end && align_err && !long_err,
                    frame_end && crc_bad && !long_err}; // R07 R08 R10

  logic [7:0] next_cnt [3];
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (cnt_inc[i])
        next_cnt[i] = rd_clr[i] ? 8'h01 : (cnt[i] == CNT_MAX ? CNT_MAX : cnt[i] + 8'h01); // R12
      else
        next_cnt[i] = rd_clr[i] ? 8'h00 : cnt[i]; // R12
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 3; i++)
        cnt[i] <= '0;
      frame_status <= '0;
      frame_done <= 1'b0;
      frame_keep <= 1'b0;
      irq_overflow <= 1'b0;
      irq_rx_error <= 1'b0;
      irq_counter <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
        cnt[i] <= next_cnt[i];
      irq_counter <= (next_cnt[0] == CNT_ALERT && cnt[0] != CNT_ALERT)
                  || (next_cnt[1] == CNT_ALERT && cnt[1] != CNT_ALERT)
                  || (next_cnt[2] == CNT_ALERT && cnt[2] != CNT_ALERT); // R13
      irq_overflow <= go_over && !overflow; // R06
      irq_rx_error <= frame_end && crc_bad && !monitor; // R09
      frame_done <= frame_end;
      frame_keep <= frame_end && acceptable && !monitor && !overflow; // R07
      if (frame_end)
      begin
        frame_status <= '0; // R11
        frame_status[ST_RECEIVED] <= acceptable && !overflow;
        frame_status[ST_CRC_ERR] <= crc_bad;
        frame_status[ST_ALIGN_ERR] <= align_err;
        frame_status[ST_RUNT] <= runt;
        frame_status[ST_LONG] <= long_err;
        frame_status[ST_OVERFLOW] <= overflow;
        frame_status[ST_MISSED] <= missed;
        frame_status[ST_COUNT_LSB +: 16] <= byte_cnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Deference timer in bit times
  logic [7:0] defer_cnt;
  wire line_busy = crs_s || col_s || tx_en;
  wire [7:0] defer_step = nibble ? 8'h04 : 8'h01;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      defer_cnt <= IFG_BITS;
    // An expired timer restarts on new activity; a frame queued at expiry has already started
    else if ((defer_cnt < OBSERVE_BITS || defer_cnt >= IFG_BITS) && line_busy)
      defer_cnt <= '0; // R19 R20 R24
    else if (defer_cnt < IFG_BITS && tx_edge)
      defer_cnt <= defer_cnt + defer_step; // R21 R24
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sequencer
  tx_state_t tx_state;
  logic [7:0] tx_byte;
  logic [2:0] tx_unit;
  logic [2:0] tx_idx;
  logic tx_is_last;
  logic tx_skip_crc;
  logic [31:0] tx_crc;
  logic [31:0] tx_crc_nx;

  wire tx_busy = tx_state != TX_IDLE;
  wire unit_end = tx_unit == (nibble ? 3'h1 : 3'h7);
  wire tx_adv = tx_edge && tx_busy && unit_end;
  wire tx_start = !tx_busy && !tx_en && tx_valid && defer_cnt >= IFG_BITS; // R19 R21
  wire [3:0] tx_out = nibble ? (tx_unit[0] ? tx_byte[7:4] : tx_byte[3:0]) // R16
                             : {3'b000, tx_byte[tx_unit]}; // R15
  assign tx_ready = tx_adv && ((tx_state == TX_PRE && tx_idx == SFD_INDEX)
                               || (tx_state == TX_DATA && !tx_is_last));

  mac_crc_byte u_tx_crc (
    .crc(tx_crc),
    .data(tx_byte),
    .next_crc(tx_crc_nx)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_state <= TX_IDLE;
      tx_byte <= '0;
      tx_unit <= '0;
      tx_idx <= '0;
      tx_is_last <= 1'b0;
      tx_skip_crc <= 1'b0;
      tx_crc <= CRC_INIT;
      tx_en <= 1'b0;
      txd <= '0;
    end
    else
    begin
      if (tx_edge)
      begin
        tx_en <= tx_busy;
        txd <= tx_busy ? tx_out : 4'h0;
        tx_unit <= tx_busy && !unit_end ? tx_unit + 3'h1 : 3'h0;
      end
      if (tx_adv && tx_ready)
      begin
        tx_byte <= tx_data;
        tx_is_last <= tx_last;
        if (tx_state == TX_PRE)
          tx_skip_crc <= tx_no_crc;
      end
      case (tx_state)
        TX_IDLE:
          if (tx_start)
          begin
            tx_state <= TX_PRE;
            tx_byte <= PREAMBLE_BYTE; // R14
            tx_idx <= '0;
            tx_crc <= CRC_INIT;
          end
        TX_PRE:
          if (tx_adv)
          begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == SFD_INDEX)
              tx_state <= TX_DATA;
            else if (tx_idx + 3'h1 == SFD_INDEX)
              tx_byte <= SFD_BYTE; // R14
          end
        TX_DATA:
          if (tx_adv)
          begin
            tx_crc <= tx_crc_nx; // R17
            if (tx_is_last)
            begin
              tx_state <= tx_skip_crc ? TX_IDLE : TX_CRC; // R18
              tx_idx <= '0;
              tx_byte <= ~tx_crc_nx[7:0]; // R17
            end
          end
        TX_CRC:
          if (tx_adv)
          begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == 3'h3)
              tx_state <= TX_IDLE;
            else
              tx_byte <= ~tx_crc[8*(tx_idx[1:0]+2'b01) +: 8]; // R17
          end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_burst;
    @(posedge clk) disable iff (!arst_n)
    fifo_cnt >= (PW+1)'(FIFO_BURST) |-> mem_burst_req;
  endproperty
  a_burst: assert property (p_burst) else $error("burst request missing"); // R03

  property p_reject;
    @(posedge clk) disable iff (!arst_n)
    in_frame && addr_reject |=> fifo_cnt == '0 && !storing;
  endproperty
  a_reject: assert property (p_reject) else $error("FIFO not reset on reject"); // R04

  property p_sat;
    @(posedge clk) disable iff (!arst_n)
    cnt[0] == CNT_MAX && !rd_clr[0] |=> cnt[0] == CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("counter left saturation"); // R12

  property p_cnt_irq;
    @(posedge clk) disable iff (!arst_n)
    cnt[0] == CNT_ALERT && $past(cnt[0]) != CNT_ALERT |-> irq_counter;
  endproperty
  a_cnt_irq: assert property (p_cnt_irq) else $error("counter interrupt missing"); // R13

  property p_defer;
    @(posedge clk) disable iff (!arst_n)
    $rose(tx_busy) |-> $past(defer_cnt) >= IFG_BITS && tx_byte == PREAMBLE_BYTE;
  endproperty
  a_defer: assert property (p_defer) else $error("start inside deference"); // R19

  property p_observe;
    @(posedge clk) disable iff (!arst_n)
    defer_cnt < OBSERVE_BITS && line_busy |=> defer_cnt == '0;
  endproperty
  a_observe: assert property (p_observe) else $error("observe part not cleared"); // R20

  property p_rx_err;
    @(posedge clk) disable iff (!arst_n)
    frame_end && crc_bad && !monitor |=> irq_rx_error && frame_status[ST_CRC_ERR];
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("receive error not raised"); // R09

  property p_runt;
    @(posedge clk) disable iff (!arst_n)
    frame_done && frame_status[ST_RUNT] && !ctrl[CTRL_ACCEPT_RUNTS] |-> !frame_keep;
  endproperty
  a_runt: assert property (p_runt) else $error("runt frame kept"); // R02

endmodule
`default_nettype wire

// [test/phy_model.sv]
`timescale 1ns/10ps
`default_nettype none
module phy_model
(
  output logic rx_clk,
  output logic crs,
  output logic rx_dv,
  output logic [3:0] rxd,
  output logic tx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic nibble,
  output logic [7:0] cap_byte,
  output var int cap_cnt
);
  logic [7:0] sh;
  int n;
  initial
  begin
    {rx_clk, crs, rx_dv, rxd, sh, cap_byte} = '0;
    {n, cap_cnt} = '0;
    tx_clk = 1'b0;
    // The MAC times deference on this clock, so it runs free
    #13;
    forever #160 tx_clk = ~tx_clk;
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge tx_clk)
  begin
    if (tx_en === 1'b1)
    begin
      sh = nibble ? {txd, sh[7:4]} : {txd[0], sh[7:1]};
      n = n + (nibble ? 4 : 1);
      if (n == 8)
      begin
        cap_byte = sh;
        n = 0;
        cap_cnt++;
      end
    end
    else
      n = 0;
  end
  ////////////////////////////////////////////////////////////////
  task automatic beat(input logic [3:0] d);
    rxd = d;
    #160 rx_clk = 1'b1;
    #160 rx_clk = 1'b0;
  endtask
  task automatic send(input logic [7:0] b[$], input logic nib, input int extra);
    logic [7:0] q[$];
    q = b;
    q.push_front(8'hD5);
    repeat (7) q.push_front(8'h55);
    #7;
    crs = 1'b1;
    rx_dv = nib;
    foreach (q[i])
      if (nib)
      begin
        beat(q[i][3:0]);
        beat(q[i][7:4]);
      end
      else
        for (int k = 0; k < 8; k++)
          beat({3'b000, q[i][k]});
    repeat (extra) beat(4'h1);
    {crs, rx_dv} = 2'b00;
    // A released bus must not look like the last value held
    rxd = ~rxd;
    #400;
  endtask
endmodule
`default_nettype wire

// [test/mac_frame_test.sv]
`timescale 1ns/10ps
`default_nettype none
module mac_frame_test;
  import mac_pkg::*;
  logic clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, mem_ready = 0, nib = 0, mem_chk = 0;
  logic tx_valid = 0, tx_last = 0, tx_no_crc = 0, burst_seen = 0;
  logic rx_er = 0, addr_reject = 0, mem_full = 0;
  logic [7:0] adr = 0, tx_data = 0;
  logic [31:0] wdat = 0;
  wire logic ack_o, rx_clk, crs, rx_dv, tx_clk, tx_en, mem_burst_req, mem_valid, frame_done;
  wire logic tx_ready, irq_rx_error, irq_counter, frame_keep, irq_overflow;
  wire logic [3:0] rxd, txd;
  wire logic [7:0] cap_byte;
  wire logic [31:0] dat_o, mem_data, frame_status;
  int cap_cnt, bad_count = 0, samples_checked = 0, cyc_n = 0, n_err = 0, n_cnt = 0, n_ovf = 0;
  time t_q = 0;
  logic [31:0] exp_rd[$], exp_st[$], exp_mem[$];
  logic [7:0] exp_tx[$];

  mac_frame DUT (.clk(clk), .arst_n(arst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .rx_clk(rx_clk), .crs(crs),
    .col(1'b0), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .tx_clk(tx_clk), .tx_en(tx_en),
    .txd(txd), .addr_reject(addr_reject), .mem_full(mem_full), .mem_burst_req(mem_burst_req),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_data(mem_data),
    .frame_done(frame_done), .frame_keep(frame_keep), .frame_status(frame_status),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_no_crc(tx_no_crc),
    .tx_ready(tx_ready), .irq_overflow(irq_overflow), .irq_rx_error(irq_rx_error),
    .irq_counter(irq_counter));
  phy_model u_phy (.rx_clk(rx_clk), .crs(crs), .rx_dv(rx_dv), .rxd(rxd), .tx_clk(tx_clk),
    .tx_en(tx_en), .txd(txd), .nibble(nib), .cap_byte(cap_byte), .cap_cnt(cap_cnt));

  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchers are on the falling edge so registered outputs have settled
  always @(negedge clk)
  begin
    if (ack_o === 1'b1 && !we)
      check(dat_o, exp_rd.pop_front());
    if (frame_done === 1'b1)
    begin
      check(32'(frame_keep), 32'(exp_st[0][ST_RECEIVED] && !exp_st[0][ST_MISSED]));
      check(frame_status, exp_st.pop_front());
    end
    if (mem_chk && mem_valid === 1'b1 && mem_ready)
      check(mem_data, exp_mem.pop_front());
    if (crs && mem_burst_req === 1'b1)
      burst_seen = 1'b1;
    n_err += int'(irq_rx_error === 1'b1);
    n_cnt += int'(irq_counter === 1'b1);
    n_ovf += int'(irq_overflow === 1'b1);
  end
  always @(cap_cnt)
    check(32'(cap_byte), 32'(exp_tx.pop_front()));
  always @(negedge crs or negedge tx_en)
    t_q = $time;
  always @(posedge tx_en)
    check(32'($time - t_q >= (nib ? 23 : 95) * 320), 1);
  always @(posedge clk)
    if (++cyc_n == 90000)
    begin
      bad_count++;
      print_verdict();
    end
  ////////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    if (!w)
      exp_rd.push_back(e);
    do @(posedge clk); while (ack_o !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  function automatic logic [31:0] crc32(input logic [7:0] b[$]);
    logic [31:0] c;
    c = CRC_INIT;
    foreach (b[i])
    begin
      c ^= 32'(b[i]);
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  task automatic rx(input int n, input logic bad, input int extra, input logic [31:0] st);
    logic [7:0] b[$];
    logic [31:0] c;
    repeat (n) b.push_back(8'($urandom));
    c = crc32(b) ^ 32'(bad);
    for (int i = 0; i < 4; i++)
      b.push_back(c[8*i +: 8]);
    exp_st.push_back(st | (32'(n + 5) << ST_COUNT_LSB));
    if (mem_chk)
      for (int i = 0; i < (n + 4) / 4; i++)
        exp_mem.push_back({b[4*i+3], b[4*i+2], b[4*i+1], b[4*i]});
    u_phy.send(b, nib, extra);
  endtask
  task automatic tx(input int n, input logic nocrc);
    logic [7:0] b[$];
    logic [31:0] c;
    repeat (n) b.push_back(8'($urandom));
    repeat (7) exp_tx.push_back(8'h55);
    exp_tx.push_back(8'hD5);
    foreach (b[i])
      exp_tx.push_back(b[i]);
    c = crc32(b);
    for (int i = 0; i < 4 && !nocrc; i++)
      exp_tx.push_back(c[8*i +: 8]);
    @(posedge clk);
    foreach (b[i])
    begin
      {tx_valid, tx_data, tx_last, tx_no_crc} <= {1'b1, b[i], i == n - 1, nocrc};
      do @(posedge clk); while (tx_ready !== 1'b1);
    end
    tx_valid <= 1'b0;
    while (exp_tx.size() > 0)
      @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h0000_30B6));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    wb(0, OFF_CTRL, 0, 0);
    wb(0, OFF_SLOT, 0, 32'h0000_0200);
    wb(0, 8'h20, 0, 0);
    wb(1, OFF_SLOT, 32'h0000_0040, 0);
    wb(0, OFF_SLOT, 0, 32'h0000_0040);
    $display("registers done");
    mem_chk = 1'b1;
    rx(24, 0, 0, 32'h1 << ST_RECEIVED);
    check(32'(burst_seen), 1);
    mem_ready <= 1'b1;
    while (exp_mem.size() > 0)
      @(posedge clk);
    mem_chk = 1'b0;
    fork
      rx(24, 0, 0, 0);
      begin
        repeat (600) @(posedge clk);
        addr_reject <= 1'b1;
        @(posedge clk);
        addr_reject <= 1'b0;
      end
    join
    fork
      rx(24, 0, 0, (32'h1 << ST_OVERFLOW) | (32'h1 << ST_MISSED));
      begin
        repeat (600) @(posedge clk);
        mem_full <= 1'b1;
        @(posedge clk);
        mem_full <= 1'b0;
      end
    join
    wb(0, OFF_MISS_CNT, 0, 1);
    check(32'(n_ovf), 1);
    $display("serial receive done");
    rx(12, 1, 0, 32'h1 << ST_CRC_ERR);
    rx(12, 1, 4, (32'h1 << ST_CRC_ERR) | (32'h1 << ST_ALIGN_ERR));
    rx(2, 0, 0, 32'h1 << ST_RUNT);
    wb(0, OFF_CRC_CNT, 0, 2);
    wb(0, OFF_ALIGN_CNT, 0, 1);
    wb(0, OFF_CRC_CNT, 0, 0);
    check(32'(n_err), 2);
    $display("error checking done");
    // Queued right after carrier drops, so start must wait out deference
    tx(6, 0);
    tx(6, 1);
    $display("serial transmit done");
    wb(1, OFF_CTRL, 32'h0000_0010, 0);
    nib <= 1'b1;
    tx(5, 0);
    rx(12, 0, 0, 32'h1 << ST_RECEIVED);
    wb(1, OFF_CTRL, 32'h0000_0014, 0);
    rx(4, 0, 0, (32'h1 << ST_RECEIVED) | (32'h1 << ST_MISSED));
    wb(1, OFF_CTRL, 32'h0000_0010, 0);
    wb(0, OFF_MISS_CNT, 0, 1);
    @(posedge clk);
    rx_er <= 1'b1;
    rx(4, 0, 0, 32'h1 << ST_CRC_ERR);
    @(posedge clk);
    rx_er <= 1'b0;
    repeat (191) rx(4, 1, 0, 32'h1 << ST_CRC_ERR);
    check(32'(n_cnt), 1);
    wb(0, OFF_CRC_CNT, 0, 32'h0000_00C0);
    $display("nibble mode done");
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule
`default_nettype wire
